// ===== rtl/status_flag_priority_indicator.sv
// Purpose: Builds the system error word and the indicator priority code.
// Assumes: All inputs come from logic on core_clk; no synchronisers needed.
// Notes:   Both words are registered; reads return the registered words.
//          The auxiliary-output mask hides indicator levels 2 and 3 only;
//          the error word always shows the raw link and range faults.
//          Jam recovery follows its triggers with no hold time.
//          An unmapped read index returns zero with rd_unmapped set.

`timescale 1ns/1ps

module status_flag_priority_indicator (
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic [15:0]                 battery_voltage,
   input  wire logic [15:0]                 supply36_voltage,
   input  wire logic [15:0]                 supply5_voltage,
   input  wire logic [15:0]                 temperature,
   input  wire logic [15:0]                 motor_current,
   input  wire logic                        positioning_link_fail,
   input  wire logic                        charge_link_fail,
   input  wire logic                        motor_link_fail,
   input  wire logic                        motor_fault_report,
   input  wire logic                        aux_output_off,
   input  wire logic                        positioning_acquiring,
   input  wire logic                        rd_en,
   input  wire logic [15:0]                 rd_addr,
   output logic [status_pkg::DATA_W-1:0]    system_error_flags,
   output logic [status_pkg::DATA_W-1:0]    indicator_priority_code,
   output logic [status_pkg::DATA_W-1:0]    rd_data,
   output logic                             rd_valid,
   output logic                             rd_unmapped
);

   import status_pkg::*;

   // --------------------------------------------------------------------
   // Helper functions.
   // --------------------------------------------------------------------
   function automatic logic exceeds(input logic [15:0] value,
                                    input logic [15:0] limit);
      exceeds = value > limit;
   endfunction : exceeds

   function automatic logic is_mapped(input logic [15:0] addr);
      is_mapped = (addr == REG_SYSTEM_ERROR_FLAGS) ||
                  (addr == REG_INDICATOR_PRIORITY_CODE);
   endfunction : is_mapped

   // --------------------------------------------------------------------
   // Declarations.
   // --------------------------------------------------------------------
   logic                battery_oor;
   logic                battery_below;
   logic                supply36_oor;
   logic                supply5_oor;
   logic                temperature_oor;
   logic                battery_low_warn;
   logic                jam_recovery_mode;
   logic                current_warn;
   logic                supply36_shown;
   logic                motor_link_shown;
   logic                analog_out_of_range;
   logic [DATA_W-1:0]   next_system_error_flags;
   logic [DATA_W-1:0]   next_indicator_priority_code;
   logic [DATA_W-1:0]   next_rd_data;
   logic                next_rd_valid;
   logic                next_rd_unmapped;

   // --------------------------------------------------------------------
   // Window monitors on the analog measurements.
   // --------------------------------------------------------------------
   window_monitor #(
      .LOW_LIMIT    (BATTERY_LOW_LIMIT),
      .HIGH_LIMIT   (BATTERY_HIGH_LIMIT),
      .IS_SIGNED    (1'b0)
   ) u_battery_window (
      .value        (battery_voltage),
      .below        (),
      .above        (),
      .out_of_range (battery_oor)
   );

   window_monitor #(
      .LOW_LIMIT    (BATTERY_WARN_LIMIT),
      .HIGH_LIMIT   (16'hFFFF),
      .IS_SIGNED    (1'b0)
   ) u_battery_warn (
      .value        (battery_voltage),
      .below        (battery_below),
      .above        (),
      .out_of_range ()
   );

   window_monitor #(
      .LOW_LIMIT    (SUPPLY36_LOW_LIMIT),
      .HIGH_LIMIT   (SUPPLY36_HIGH_LIMIT),
      .IS_SIGNED    (1'b0)
   ) u_supply36_window (
      .value        (supply36_voltage),
      .below        (),
      .above        (),
      .out_of_range (supply36_oor)
   );

   window_monitor #(
      .LOW_LIMIT    (SUPPLY5_LOW_LIMIT),
      .HIGH_LIMIT   (SUPPLY5_HIGH_LIMIT),
      .IS_SIGNED    (1'b0)
   ) u_supply5_window (
      .value        (supply5_voltage),
      .below        (),
      .above        (),
      .out_of_range (supply5_oor)
   );

   window_monitor #(
      .LOW_LIMIT    (TEMP_LOW_LIMIT),
      .HIGH_LIMIT   (TEMP_HIGH_LIMIT),
      .IS_SIGNED    (1'b1)
   ) u_temperature_window (
      .value        (temperature),
      .below        (),
      .above        (),
      .out_of_range (temperature_oor)
   );

   // --------------------------------------------------------------------
   // Condition decode.
   // --------------------------------------------------------------------
   always_comb
   begin
      battery_low_warn    = battery_below;
      // Over-current and the motor fault report both start jam recovery.
      jam_recovery_mode   = exceeds(motor_current, JAM_CURRENT_LIMIT) |
                            motor_fault_report;
      current_warn        = exceeds(motor_current, WARN_CURRENT_LIMIT);
      supply36_shown      = supply36_oor & ~aux_output_off;
      motor_link_shown    = motor_link_fail & ~aux_output_off;
      analog_out_of_range = battery_oor | supply36_oor |
                            supply5_oor | temperature_oor;
   end

   // --------------------------------------------------------------------
   // Next system error word.
   // --------------------------------------------------------------------
   always_comb
   begin
      next_system_error_flags                       = SYSTEM_ERROR_FLAGS_RESET;
      next_system_error_flags[ERR_BIT_POSITIONING]  = positioning_link_fail;
      next_system_error_flags[ERR_BIT_CHARGE]       = charge_link_fail;
      next_system_error_flags[ERR_BIT_MOTOR]        = motor_link_fail;
      next_system_error_flags[ERR_BIT_OUT_OF_RANGE] = analog_out_of_range;
   end

   // --------------------------------------------------------------------
   // System error word register.
   // --------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         system_error_flags <= SYSTEM_ERROR_FLAGS_RESET;
      end
      else
      begin
         system_error_flags <= next_system_error_flags;
      end
   end

   // --------------------------------------------------------------------
   // Next indicator code, highest precedence first.
   // --------------------------------------------------------------------
   always_comb
   begin
      if (battery_oor)
      begin
         next_indicator_priority_code = CODE_RED_5;
      end
      else if (jam_recovery_mode)
      begin
         next_indicator_priority_code = CODE_RED_1;
      end
      else if (supply36_shown)
      begin
         next_indicator_priority_code = CODE_RED_2;
      end
      else if (motor_link_shown)
      begin
         next_indicator_priority_code = CODE_RED_3;
      end
      else if (charge_link_fail)
      begin
         next_indicator_priority_code = CODE_RED_4;
      end
      else if (current_warn)
      begin
         next_indicator_priority_code = CODE_YELLOW_1;
      end
      else if (battery_low_warn)
      begin
         next_indicator_priority_code = CODE_YELLOW_2;
      end
      else if (temperature_oor)
      begin
         next_indicator_priority_code = CODE_YELLOW_3;
      end
      else if (supply5_oor)
      begin
         next_indicator_priority_code = CODE_YELLOW_4;
      end
      else if (positioning_link_fail)
      begin
         next_indicator_priority_code = CODE_YELLOW_5;
      end
      // The acquiring code ranks below every fault and above healthy.
      else if (positioning_acquiring)
      begin
         next_indicator_priority_code = CODE_ACQUIRING;
      end
      else
      begin
         next_indicator_priority_code = CODE_HEALTHY;
      end
   end

   // --------------------------------------------------------------------
   // Indicator code register.
   // --------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         indicator_priority_code <= INDICATOR_CODE_RESET;
      end
      else
      begin
         indicator_priority_code <= next_indicator_priority_code;
      end
   end

   // --------------------------------------------------------------------
   // Register read port.
   // --------------------------------------------------------------------
   always_comb
   begin
      next_rd_valid    = rd_en;
      next_rd_unmapped = rd_en & ~is_mapped(rd_addr);
      next_rd_data     = READ_DATA_RESET;
      // A read returns each word as it stood before this edge.
      if (rd_en && (rd_addr == REG_SYSTEM_ERROR_FLAGS))
      begin
         next_rd_data = system_error_flags;
      end
      else if (rd_en && (rd_addr == REG_INDICATOR_PRIORITY_CODE))
      begin
         next_rd_data = indicator_priority_code;
      end
   end

   // --------------------------------------------------------------------
   // Read port registers.
   // --------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_data     <= READ_DATA_RESET;
         rd_valid    <= 1'b0;
         rd_unmapped <= 1'b0;
      end
      else
      begin
         rd_data     <= next_rd_data;
         rd_valid    <= next_rd_valid;
         rd_unmapped <= next_rd_unmapped;
      end
   end

endmodule : status_flag_priority_indicator

// ===== rtl/status_pkg.sv
// Purpose: Shared constants for the status flag and priority indicator block.
// Assumes: Measurements arrive already digitized on the core_clk domain.
// Notes:   Voltages in tenths of a volt, 5V rail in hundredths, current in mA,
//          temperature in whole degrees Fahrenheit as a signed word.

package status_pkg;

   // --------------------------------------------------------------------
   // Register indices and widths.
   // --------------------------------------------------------------------
   localparam int          DATA_W                      = 16;
   localparam logic [15:0] REG_SYSTEM_ERROR_FLAGS      = 16'h0007;
   localparam logic [15:0] REG_INDICATOR_PRIORITY_CODE = 16'h0009;
   localparam logic [15:0] SYSTEM_ERROR_FLAGS_RESET    = 16'h0000;
   localparam logic [15:0] INDICATOR_CODE_RESET        = 16'h0000;
   localparam logic [15:0] READ_DATA_RESET             = 16'h0000;

   // --------------------------------------------------------------------
   // Bit positions of the system error word.
   // --------------------------------------------------------------------
   localparam int ERR_BIT_POSITIONING = 0;
   localparam int ERR_BIT_CHARGE      = 1;
   localparam int ERR_BIT_MOTOR       = 2;
   localparam int ERR_BIT_OUT_OF_RANGE = 3;

   // --------------------------------------------------------------------
   // Threshold limits.
   // --------------------------------------------------------------------
   localparam logic [15:0] BATTERY_LOW_LIMIT    = 16'h0072;  // 11.4 V
   localparam logic [15:0] BATTERY_HIGH_LIMIT   = 16'h00AF;  // 17.5 V
   localparam logic [15:0] BATTERY_WARN_LIMIT   = 16'h0079;  // 12.1 V
   localparam logic [15:0] SUPPLY36_LOW_LIMIT   = 16'h014A;  // 33.0 V
   localparam logic [15:0] SUPPLY36_HIGH_LIMIT  = 16'h0186;  // 39.0 V
   localparam logic [15:0] SUPPLY5_LOW_LIMIT    = 16'h01C2;  // 4.50 V
   localparam logic [15:0] SUPPLY5_HIGH_LIMIT   = 16'h0226;  // 5.50 V
   localparam logic [15:0] TEMP_LOW_LIMIT       = 16'h0000;  // 0 F
   localparam logic [15:0] TEMP_HIGH_LIMIT      = 16'h00B0;  // 176 F
   localparam logic [15:0] JAM_CURRENT_LIMIT    = 16'h1194;  // 4500 mA
   localparam logic [15:0] WARN_CURRENT_LIMIT   = 16'h0DAC;  // 3500 mA

   // --------------------------------------------------------------------
   // Indicator codes: red count in the low nibble, yellow count times 16.
   // --------------------------------------------------------------------
   localparam logic [15:0] CODE_HEALTHY        = 16'h0000;
   localparam logic [15:0] CODE_RED_1          = 16'h0001;
   localparam logic [15:0] CODE_RED_2          = 16'h0002;
   localparam logic [15:0] CODE_RED_3          = 16'h0003;
   localparam logic [15:0] CODE_RED_4          = 16'h0004;
   localparam logic [15:0] CODE_RED_5          = 16'h0005;
   localparam logic [15:0] CODE_YELLOW_1       = 16'h0010;
   localparam logic [15:0] CODE_YELLOW_2       = 16'h0020;
   localparam logic [15:0] CODE_YELLOW_3       = 16'h0030;
   localparam logic [15:0] CODE_YELLOW_4       = 16'h0040;
   localparam logic [15:0] CODE_YELLOW_5       = 16'h0050;
   localparam logic [15:0] CODE_ACQUIRING      = 16'h0100;

endpackage : status_pkg

// ===== rtl/window_monitor.sv
// Purpose: Flags a measurement that lies below or above a fixed window.
// Assumes: Limits are constants; the value is stable within the cycle.
// Notes:   Purely combinational; the caller registers the result.

`timescale 1ns/1ps

module window_monitor #(
   parameter logic [15:0] LOW_LIMIT  = 16'h0000,
   parameter logic [15:0] HIGH_LIMIT = 16'hFFFF,
   parameter bit          IS_SIGNED  = 1'b0
) (
   input  wire logic [15:0] value,
   output logic             below,
   output logic             above,
   output logic             out_of_range
);

   // --------------------------------------------------------------------
   // Window comparison.
   // --------------------------------------------------------------------
   always_comb
   begin
      if (IS_SIGNED)
      begin
         below = $signed(value) < $signed(LOW_LIMIT);
         above = $signed(value) > $signed(HIGH_LIMIT);
      end
      else
      begin
         below = value < LOW_LIMIT;
         above = value > HIGH_LIMIT;
      end
      out_of_range = below | above;
   end

endmodule : window_monitor

// ===== testbench/status_flag_priority_indicator_assertions.sv
// Purpose: Concurrent checks on the status words and the read port.
// Assumes: Bound to every instance of the status block.
// Notes:   Both words lag their inputs by one core_clk edge.
`timescale 1ns/1ps
module status_flag_priority_indicator_assertions (
   input wire logic                          core_clk,
   input wire logic                          rst_n,
   input wire logic [15:0]                   battery_voltage,
   input wire logic [15:0]                   supply36_voltage,
   input wire logic [15:0]                   supply5_voltage,
   input wire logic [15:0]                   temperature,
   input wire logic [15:0]                   motor_current,
   input wire logic                          positioning_link_fail,
   input wire logic                          charge_link_fail,
   input wire logic                          motor_link_fail,
   input wire logic                          motor_fault_report,
   input wire logic                          aux_output_off,
   input wire logic                          positioning_acquiring,
   input wire logic                          rd_en,
   input wire logic [15:0]                   rd_addr,
   input wire logic [status_pkg::DATA_W-1:0] system_error_flags,
   input wire logic [status_pkg::DATA_W-1:0] indicator_priority_code,
   input wire logic [status_pkg::DATA_W-1:0] rd_data,
   input wire logic                          rd_valid,
   input wire logic                          rd_unmapped
);
   import status_pkg::*;
   logic batt_oor;
   logic any_oor;
   assign batt_oor = battery_voltage < 16'h0072 || battery_voltage > 16'h00AF;
   assign any_oor  = batt_oor || supply36_voltage < 16'h014A || supply36_voltage > 16'h0186
                     || supply5_voltage < 16'h01C2 || supply5_voltage > 16'h0226
                     || $signed(temperature) < $signed(16'h0000)
                     || $signed(temperature) > $signed(16'h00B0);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_err_receiver_bit: assert property ($past(rst_n) |->
      system_error_flags[0] == $past(positioning_link_fail)) else $error("receiver bit wrong");
   a_err_charge_bit: assert property ($past(rst_n) |->
      system_error_flags[1] == $past(charge_link_fail)) else $error("charge bit wrong");
   a_err_motor_bit: assert property ($past(rst_n) |->
      system_error_flags[2] == $past(motor_link_fail)) else $error("motor bit wrong");
   a_err_range_bit: assert property ($past(rst_n) |->
      system_error_flags[3] == $past(any_oor)) else $error("range bit wrong");
   a_code_battery_top: assert property ($past(rst_n) && $past(batt_oor) |->
      indicator_priority_code == 16'h0005) else $error("battery level wrong");
   a_code_jam_next: assert property ($past(rst_n) && !$past(batt_oor)
      && ($past(motor_current) > 16'h1194 || $past(motor_fault_report))
      |-> indicator_priority_code == 16'h0001) else $error("jam level wrong");
   a_aux_hides_levels: assert property ($past(rst_n) && $past(aux_output_off) |->
      indicator_priority_code != 16'h0002 && indicator_priority_code != 16'h0003)
      else $error("aux mask wrong");
   a_code_form: assert property (indicator_priority_code[3:0] != 4'h0 |->
      indicator_priority_code[15:4] == 12'h000) else $error("code form wrong");
   a_read_code_word: assert property (rd_en && rd_addr == 16'h0009 |=>
      rd_valid && rd_data == $past(indicator_priority_code)) else $error("read word wrong");
   a_read_unmapped_zero: assert property (rd_en && rd_addr != 16'h0007
      && rd_addr != 16'h0009
      |=> rd_valid && rd_unmapped && rd_data == 16'h0000) else $error("unmapped wrong");
endmodule : status_flag_priority_indicator_assertions
bind status_flag_priority_indicator status_flag_priority_indicator_assertions chk_u (
   .core_clk(core_clk), .rst_n(rst_n), .battery_voltage(battery_voltage),
   .supply36_voltage(supply36_voltage), .supply5_voltage(supply5_voltage),
   .temperature(temperature), .motor_current(motor_current),
   .positioning_link_fail(positioning_link_fail), .charge_link_fail(charge_link_fail),
   .motor_link_fail(motor_link_fail), .motor_fault_report(motor_fault_report),
   .aux_output_off(aux_output_off), .positioning_acquiring(positioning_acquiring),
   .rd_en(rd_en), .rd_addr(rd_addr), .system_error_flags(system_error_flags),
   .indicator_priority_code(indicator_priority_code), .rd_data(rd_data),
   .rd_valid(rd_valid), .rd_unmapped(rd_unmapped));

// ===== testbench/status_poller.sv
// Purpose: Polling master model that reads the two status words.
// Assumes: One read in flight at a time.
// Notes:   The address lines show the inverse of the last index when idle.
`timescale 1ns/1ps
module status_poller (
   input  wire logic        core_clk,
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_valid,
   input  wire logic        rd_unmapped,
   output logic             rd_en,
   output logic [15:0]      rd_addr
);
   initial
   begin
      rd_en   = 1'b0;
      rd_addr = 16'h0000;
   end
   task automatic read_reg(input logic [15:0] a, input int gap,
                           output logic [15:0] d, output logic [1:0] vu);
      repeat (gap) @(posedge core_clk);
      @(posedge core_clk);
      #2;
      rd_en   = 1'b1;
      rd_addr = a;
      @(posedge core_clk);
      #2;
      d       = rd_data;
      vu      = {rd_valid, rd_unmapped};
      rd_en   = 1'b0;
      rd_addr = ~a;
   endtask : read_reg
endmodule : status_poller

// ===== testbench/status_flag_priority_indicator_tb.sv
// Purpose: Self-checking bench for the status flag priority indicator.
// Assumes: Inputs change 2 ns after the rising edge of core_clk.
// Notes:   The poller model reads the words over the read port.
`timescale 1ns/1ps
module status_flag_priority_indicator_tb;
   import status_pkg::*;
   localparam logic [4:0][15:0] NOM = {16'h0082, 16'h0168, 16'h01F4, 16'h0046, 16'h03E8};
   logic             core_clk;
   logic             rst_n;
   logic [4:0][15:0] meas;
   logic [5:0]       flg;
   logic [15:0]      battery_voltage, supply36_voltage, supply5_voltage;
   logic [15:0]      temperature, motor_current;
   logic             positioning_link_fail, charge_link_fail, motor_link_fail;
   logic             motor_fault_report, aux_output_off, positioning_acquiring;
   logic             rd_en, rd_valid, rd_unmapped;
   logic [15:0]      rd_addr, system_error_flags, indicator_priority_code, rd_data;
   int               bad_count = 0;
   int               total_checks = 0;
   assign {battery_voltage, supply36_voltage, supply5_voltage, temperature, motor_current} = meas;
   assign {positioning_acquiring, aux_output_off, motor_fault_report, motor_link_fail,
           charge_link_fail, positioning_link_fail} = flg;
   status_flag_priority_indicator dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .battery_voltage(battery_voltage), .supply36_voltage(supply36_voltage),
      .supply5_voltage(supply5_voltage), .temperature(temperature),
      .motor_current(motor_current), .positioning_link_fail(positioning_link_fail),
      .charge_link_fail(charge_link_fail), .motor_link_fail(motor_link_fail),
      .motor_fault_report(motor_fault_report), .aux_output_off(aux_output_off),
      .positioning_acquiring(positioning_acquiring), .rd_en(rd_en), .rd_addr(rd_addr),
      .system_error_flags(system_error_flags), .indicator_priority_code(indicator_priority_code),
      .rd_data(rd_data), .rd_valid(rd_valid), .rd_unmapped(rd_unmapped));
   status_poller poll_u (.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_unmapped(rd_unmapped), .rd_en(rd_en), .rd_addr(rd_addr));
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask : chk
   task automatic setv(input int w, input logic [15:0] v, input logic [5:0] f);
      @(posedge core_clk);
      #2;
      meas = NOM;
      if (w > 0)
         meas[5-w] = v;
      flg = f;
      @(posedge core_clk);
      #1;
   endtask : setv
   task automatic row(input int w, input logic [15:0] v, input logic [5:0] f,
                      input logic [15:0] e);
      setv(w, v, f);
      chk("indicator_priority_code", e, indicator_priority_code);
   endtask : row
   task automatic t_reset;
      repeat (3) @(posedge core_clk);
      chk("system_error_flags", 16'h0000, system_error_flags);
      chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
      #2;
      rst_n = 1'b1;
      $display("test reset done");
   endtask : t_reset
   task automatic t_err_word;
      for (int i = 0; i < 16; i++)
      begin
         setv(i[3] ? 4 : 0, 16'h00C8, {3'h0, i[2:0]});
         chk("system_error_flags", i[15:0], system_error_flags);
      end
      $display("test error word done");
   endtask : t_err_word
   task automatic t_levels;
      row(0, 16'h0000, 6'h00, 16'h0000);
      row(1, 16'h0071, 6'h00, 16'h0005);
      row(1, 16'h00B0, 6'h08, 16'h0005);
      row(5, 16'h1195, 6'h00, 16'h0001);
      row(0, 16'h0000, 6'h08, 16'h0001);
      row(2, 16'h0149, 6'h08, 16'h0001);
      row(2, 16'h0149, 6'h02, 16'h0002);
      row(2, 16'h0187, 6'h00, 16'h0002);
      row(2, 16'h0149, 6'h10, 16'h0000);
      row(0, 16'h0000, 6'h04, 16'h0003);
      row(0, 16'h0000, 6'h14, 16'h0000);
      row(0, 16'h0000, 6'h16, 16'h0004);
      row(5, 16'h0DAD, 6'h01, 16'h0010);
      row(5, 16'h0DAC, 6'h00, 16'h0000);
      row(1, 16'h0078, 6'h00, 16'h0020);
      row(1, 16'h0072, 6'h00, 16'h0020);
      row(4, 16'hFFFF, 6'h00, 16'h0030);
      row(4, 16'h00B1, 6'h00, 16'h0030);
      row(3, 16'h01C1, 6'h00, 16'h0040);
      row(3, 16'h0227, 6'h20, 16'h0040);
      row(3, 16'h0226, 6'h00, 16'h0000);
      row(0, 16'h0000, 6'h21, 16'h0050);
      row(0, 16'h0000, 6'h20, 16'h0100);
      $display("test levels done");
   endtask : t_levels
   task automatic t_read;
      logic [15:0] d;
      logic [1:0]  vu;
      setv(0, 16'h0000, 6'h06);
      poll_u.read_reg(16'h0009, 0, d, vu);
      chk("rd_data code", 16'h0003, d);
      poll_u.read_reg(16'h0007, 3, d, vu);
      chk("rd_data flags", 16'h0006, d);
      chk("rd_valid", 16'h0002, {14'h0000, vu});
      poll_u.read_reg(16'h0005, 0, d, vu);
      chk("rd_data unmapped", 16'h0000, d);
      chk("rd_unmapped", 16'h0003, {14'h0000, vu});
      $display("test read done");
   endtask : t_read
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   initial
   begin
      #100000;
      bad_count++;
      results();
   end
   initial
   begin
      rst_n = 1'b0;
      meas  = NOM;
      flg   = 6'h00;
      t_reset();
      t_err_word();
      t_levels();
      t_read();
      results();
   end
endmodule : status_flag_priority_indicator_tb
